/* pmbus_fault_pkg.sv */
`default_nettype none
package pmbus_fault_pkg;

    // ----------------------------------------
    // Command codes of the status registers
    // ----------------------------------------
    localparam logic [7:0] OFS_SUMMARY_BYTE = 8'h78;
    localparam logic [7:0] OFS_SUMMARY_WORD = 8'h79;
    localparam logic [7:0] OFS_VOUT = 8'h7a;
    localparam logic [7:0] OFS_IOUT = 8'h7b;
    localparam logic [7:0] OFS_INPUT = 8'h7c;
    localparam logic [7:0] OFS_TEMP = 8'h7d;
    localparam logic [7:0] OFS_CML = 8'h7e;
    localparam logic [7:0] OFS_VENDOR = 8'h80;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] RST_VOUT = 8'h00;
    localparam logic [7:0] RST_IOUT = 8'h00;
    localparam logic [7:0] RST_INPUT = 8'h08;
    localparam logic [7:0] RST_TEMP = 8'h00;
    localparam logic [7:0] RST_CML = 8'h00;
    localparam logic [7:0] RST_VENDOR = 8'h00;
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [7:0] RST_SUMMARY_BYTE = 8'h41;
    localparam logic [7:0] RST_SUMMARY_HI = 8'h20;

    // ----------------------------------------
    // Write-one-to-clear and alert-capable positions, then the latched vendor positions
    // ----------------------------------------
    localparam logic [7:0] W1C_VOUT = 8'hfc;
    localparam logic [7:0] W1C_IOUT = 8'ha0;
    localparam logic [7:0] W1C_INPUT = 8'h08;
    localparam logic [7:0] W1C_TEMP = 8'hc0;
    localparam logic [7:0] W1C_CML = 8'hf2;
    localparam logic [7:0] W1C_VENDOR = 8'h90;
    localparam logic [7:0] LATCH_VENDOR = 8'hf8;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int VOUT_OV_FAULT_POS = 7;
    localparam int VOUT_OV_WARN_POS = 6;
    localparam int VOUT_UV_WARN_POS = 5;
    localparam int VOUT_UV_FAULT_POS = 4;
    localparam int VOUT_RANGE_POS = 3;
    localparam int VOUT_TONMAX_POS = 2;
    localparam int IOUT_OC_FAULT_POS = 7;
    localparam int IOUT_OC_WARN_POS = 5;
    localparam int INPUT_LOWVIN_POS = 3;
    localparam int TEMP_OTF_POS = 7;
    localparam int TEMP_OT_WARN_POS = 6;
    localparam int CML_CMD_POS = 7;
    localparam int CML_DATA_POS = 6;
    localparam int CML_PEC_POS = 5;
    localparam int CML_MEM_POS = 4;
    localparam int CML_OTHER_POS = 1;
    localparam int VEN_TSD_POS = 7;
    localparam int VEN_ZERO_POS = 6;
    localparam int VEN_MANY_POS = 5;
    localparam int VEN_PIN_ONE_POS = 4;
    localparam int VEN_PIN_ZERO_POS = 3;
    localparam int VEN_FOLLOW_POS = 1;
    localparam int VEN_SYNC_POS = 0;

    // ----------------------------------------
    // Counts and sizes
    // ----------------------------------------
    localparam logic [2:0] PIN_ONE_FAIL_LIMIT = 3'h4;
    localparam logic [12:0] OT_HYST_DEGC = 13'h014;
    localparam int OP_STATE_W = 6;
    localparam int NUM_STATUS = 6;

    typedef enum logic {VIN_POWERUP, VIN_RUNNING} vin_phase_t;

endpackage
`default_nettype wire

/* sticky_flags.sv */
`timescale 1ns/1ps
`default_nettype none
module sticky_flags #(
    parameter logic [7:0] RESET_VAL = 8'h00
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] set,
    input wire logic [7:0] clr,
    input wire logic [7:0] force_zero,
    output logic [7:0] flags
);
    typedef struct packed {
        logic [7:0] flags;
    } sticky_state_t;

    sticky_state_t q, d;

    // Set beats clear so a fault in the clearing cycle stays visible
    always_comb begin
        d = q;
        d.flags = ((q.flags & ~clr) | set) & ~force_zero;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q.flags <= RESET_VAL;
        end else begin
            q <= d;
        end
    end

    assign flags = q.flags;

    a_set_wins_clear: assert property (@(posedge clk) disable iff (!rst_n)
        (|(set & ~force_zero)) |=> ((flags & $past(set & ~force_zero))
            == $past(set & ~force_zero)))
        else $error("sticky flag lost its set");
endmodule
`default_nettype wire

/* ot_rearm.sv */
`timescale 1ns/1ps
`default_nettype none
module ot_rearm (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic signed [11:0] temp,
    input wire logic signed [11:0] limit,
    output logic trip
);
    import pmbus_fault_pkg::*;

    typedef struct packed {
        logic hot;
        logic trip;
    } ot_state_t;

    ot_state_t q, d;
    logic signed [12:0] low_mark;
    logic over;
    logic cool;

    // Hot stays until the reading falls the full band below the limit
    always_comb begin
        low_mark = 13'({limit[11], limit} - $signed(OT_HYST_DEGC));
        over = temp >= limit;
        cool = $signed({temp[11], temp}) <= low_mark;
        d = q;
        d.hot = over | (q.hot & ~cool);
        d.trip = over | (q.hot & ~cool);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign trip = q.trip;

    a_over_trips: assert property (@(posedge clk) disable iff (!rst_n)
        (temp >= limit) |=> trip)
        else $error("over-limit reading did not trip");
endmodule
`default_nettype wire

/* pmbus_fault_status_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module pmbus_fault_status_bank (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rd_en,
    input wire logic wr_en,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] wr_data,
    input wire logic clear_faults,
    input wire logic mask_wr_en,
    input wire logic [7:0] mask_cmd_code,
    input wire logic [7:0] mask_data,
    input wire logic vout_ov_fault,
    input wire logic vout_ov_warn,
    input wire logic vout_uv_warn,
    input wire logic vout_uv_fault,
    input wire logic setpoint_range_err,
    input wire logic turn_on_timeout,
    input wire logic loop_follower_indication,
    input wire logic oc_fault,
    input wire logic oc_warn,
    input wire logic vin_above_on,
    input wire logic vin_below_off,
    input wire logic signed [11:0] temperature,
    input wire logic signed [11:0] ot_fault_limit,
    input wire logic signed [11:0] ot_warn_limit,
    input wire logic invalid_command,
    input wire logic invalid_data,
    input wire logic pec_fail,
    input wire logic memory_fault,
    input wire logic other_comm_fault,
    input wire logic bandgap_tsd,
    input wire logic [pmbus_fault_pkg::OP_STATE_W-1:0] op_state,
    input wire logic address_pin_one_attempt,
    input wire logic address_pin_one_ok,
    input wire logic address_pin_zero_detect_fail,
    input wire logic sync_fault_live,
    input wire logic sync_fault_disable,
    input wire logic converter_enabled,
    input wire logic power_not_good,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic rd_unmapped,
    output logic smbalert_oe,
    output logic address_pin_one_use_default,
    output logic [7:0] summary_byte,
    output logic [7:0] summary_word_hi
);
    import pmbus_fault_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [NUM_STATUS-1:0][7:0] mask;
        vin_phase_t vin_phase;
        logic [2:0] pin1_fail_cnt;
        logic pin1_default;
        logic [7:0] rd_data;
        logic rd_valid;
        logic rd_unmapped;
        logic alert;
        logic [7:0] sum_byte;
        logic [7:0] sum_hi;
    } bank_state_t;

    bank_state_t q, d;

    logic [7:0] vout_q, iout_q, input_q, temp_q, cml_q, ven_q;
    logic [7:0] vout_set, iout_set, input_set, temp_set, cml_set, ven_set;
    logic [7:0] vout_clr, iout_clr, input_clr, temp_clr, cml_clr, ven_clr;
    logic [7:0] vout_force;
    logic [7:0] ven_view;
    logic [7:0] w1c;
    logic [7:0] fault_all;
    logic otf_trip, warn_trip;
    logic op_zero, op_many;
    logic pin1_fail_now;
    logic [2:0] pin1_next;
    logic [7:0] alert_vec;

    // ----------------------------------------
    // Temperature with re-arm band
    // ----------------------------------------
    ot_rearm u_otf (
        .clk(clk),
        .rst_n(rst_n),
        .temp(temperature),
        .limit(ot_fault_limit),
        .trip(otf_trip)
    );

    ot_rearm u_warn_band (
        .clk(clk),
        .rst_n(rst_n),
        .temp(temperature),
        .limit(ot_warn_limit),
        .trip(warn_trip)
    );

    // ----------------------------------------
    // Event sources
    // ----------------------------------------
    always_comb begin
        w1c = wr_data & {8{wr_en}};
        op_zero = op_state == '0;
        op_many = (op_state & (op_state - 1'b1)) != '0;
        pin1_next = 3'(q.pin1_fail_cnt + 3'h1);
        pin1_fail_now = address_pin_one_attempt & ~address_pin_one_ok
            & (pin1_next == PIN_ONE_FAIL_LIMIT);
        vout_set = '0;
        vout_set[VOUT_OV_FAULT_POS] = vout_ov_fault;
        vout_set[VOUT_OV_WARN_POS] = vout_ov_warn;
        vout_set[VOUT_UV_WARN_POS] = vout_uv_warn;
        vout_set[VOUT_UV_FAULT_POS] = vout_uv_fault;
        vout_set[VOUT_RANGE_POS] = setpoint_range_err;
        vout_set[VOUT_TONMAX_POS] = turn_on_timeout;
        vout_force = {8{loop_follower_indication}};
        iout_set = '0;
        iout_set[IOUT_OC_FAULT_POS] = oc_fault;
        iout_set[IOUT_OC_WARN_POS] = oc_warn;
        input_set = '0;
        input_clr = '0;
        if (q.vin_phase == VIN_POWERUP) begin
            input_set[INPUT_LOWVIN_POS] = ~vin_above_on;
            input_clr[INPUT_LOWVIN_POS] = vin_above_on;
        end else begin
            input_set[INPUT_LOWVIN_POS] = vin_below_off;
            if (clear_faults) begin
                input_clr = W1C_INPUT;
            end else if (cmd_code == OFS_INPUT) begin
                input_clr = w1c & W1C_INPUT;
            end
        end
        temp_set = '0;
        temp_set[TEMP_OTF_POS] = otf_trip;
        temp_set[TEMP_OT_WARN_POS] = warn_trip;
        cml_set = '0;
        cml_set[CML_CMD_POS] = invalid_command;
        cml_set[CML_DATA_POS] = invalid_data;
        cml_set[CML_PEC_POS] = pec_fail;
        cml_set[CML_MEM_POS] = memory_fault;
        cml_set[CML_OTHER_POS] = other_comm_fault;
        ven_set = '0;
        ven_set[VEN_TSD_POS] = bandgap_tsd;
        ven_set[VEN_ZERO_POS] = op_zero;
        ven_set[VEN_MANY_POS] = op_many;
        ven_set[VEN_PIN_ONE_POS] = pin1_fail_now;
        ven_set[VEN_PIN_ZERO_POS] = address_pin_zero_detect_fail;
        // Host clears; read-only positions never see a write
        vout_clr = clear_faults ? W1C_VOUT
            : (cmd_code == OFS_VOUT ? w1c & W1C_VOUT : 8'h00);
        iout_clr = clear_faults ? W1C_IOUT
            : (cmd_code == OFS_IOUT ? w1c & W1C_IOUT : 8'h00);
        temp_clr = clear_faults ? W1C_TEMP
            : (cmd_code == OFS_TEMP ? w1c & W1C_TEMP : 8'h00);
        cml_clr = clear_faults ? W1C_CML
            : (cmd_code == OFS_CML ? w1c & W1C_CML : 8'h00);
        // Only the host touches the address flag, never on or off events
        ven_clr = clear_faults ? LATCH_VENDOR
            : (cmd_code == OFS_VENDOR ? w1c & W1C_VENDOR : 8'h00);
    end

    // ----------------------------------------
    // Latched flag banks
    // ----------------------------------------
    sticky_flags #(.RESET_VAL(RST_VOUT)) u_vout (
        .clk(clk),
        .rst_n(rst_n),
        .set(vout_set),
        .clr(vout_clr),
        .force_zero(vout_force),
        .flags(vout_q)
    );

    sticky_flags #(.RESET_VAL(RST_IOUT)) u_iout (
        .clk(clk),
        .rst_n(rst_n),
        .set(iout_set),
        .clr(iout_clr),
        .force_zero(8'h00),
        .flags(iout_q)
    );

    sticky_flags #(.RESET_VAL(RST_INPUT)) u_input (
        .clk(clk),
        .rst_n(rst_n),
        .set(input_set),
        .clr(input_clr),
        .force_zero(8'h00),
        .flags(input_q)
    );

    sticky_flags #(.RESET_VAL(RST_TEMP)) u_temp (
        .clk(clk),
        .rst_n(rst_n),
        .set(temp_set),
        .clr(temp_clr),
        .force_zero(8'h00),
        .flags(temp_q)
    );

    sticky_flags #(.RESET_VAL(RST_CML)) u_cml (
        .clk(clk),
        .rst_n(rst_n),
        .set(cml_set),
        .clr(cml_clr),
        .force_zero(8'h00),
        .flags(cml_q)
    );

    sticky_flags #(.RESET_VAL(RST_VENDOR)) u_vendor (
        .clk(clk),
        .rst_n(rst_n),
        .set(ven_set),
        .clr(ven_clr),
        .force_zero(8'h00),
        .flags(ven_q)
    );

    // ----------------------------------------
    // Next state, readback and alert
    // ----------------------------------------
    always_comb begin
        d = q;
        ven_view = ven_q & LATCH_VENDOR;
        ven_view[VEN_FOLLOW_POS] = loop_follower_indication;
        ven_view[VEN_SYNC_POS] = sync_fault_live & ~sync_fault_disable;
        if (q.vin_phase == VIN_POWERUP && vin_above_on) begin
            d.vin_phase = VIN_RUNNING;
        end
        if (address_pin_one_attempt) begin
            if (address_pin_one_ok) begin
                d.pin1_fail_cnt = '0;
                d.pin1_default = 1'b0;
            end else if (pin1_fail_now) begin
                d.pin1_fail_cnt = '0;
                d.pin1_default = 1'b1;
            end else begin
                d.pin1_fail_cnt = pin1_next;
            end
        end
        // Masks live only on alert-capable positions
        if (mask_wr_en) begin
            if (mask_cmd_code == OFS_VOUT) begin
                d.mask[0] = mask_data & W1C_VOUT;
            end else if (mask_cmd_code == OFS_IOUT) begin
                d.mask[1] = mask_data & W1C_IOUT;
            end else if (mask_cmd_code == OFS_INPUT) begin
                d.mask[2] = mask_data & W1C_INPUT;
            end else if (mask_cmd_code == OFS_TEMP) begin
                d.mask[3] = mask_data & W1C_TEMP;
            end else if (mask_cmd_code == OFS_CML) begin
                d.mask[4] = mask_data & W1C_CML;
            end else if (mask_cmd_code == OFS_VENDOR) begin
                d.mask[5] = mask_data & W1C_VENDOR;
            end
        end
        // Power-up low-input stays out of the alert
        alert_vec[0] = |(vout_q & W1C_VOUT & ~q.mask[0]);
        alert_vec[1] = |(iout_q & W1C_IOUT & ~q.mask[1]);
        alert_vec[2] = (q.vin_phase == VIN_RUNNING)
            & |(input_q & W1C_INPUT & ~q.mask[2]);
        alert_vec[3] = |(temp_q & W1C_TEMP & ~q.mask[3]);
        alert_vec[4] = |(cml_q & W1C_CML & ~q.mask[4]);
        alert_vec[5] = |(ven_q & W1C_VENDOR & ~q.mask[5]);
        alert_vec[7:6] = 2'h0;
        d.alert = |alert_vec;
        // Summaries come from the detail flags plus converter_enabled and power_not_good
        fault_all = '0;
        fault_all[6] = ~converter_enabled;
        fault_all[5] = vout_q[VOUT_OV_FAULT_POS];
        fault_all[4] = iout_q[IOUT_OC_FAULT_POS];
        fault_all[2] = |temp_q;
        fault_all[1] = |cml_q;
        fault_all[0] = |(vout_q & ~(8'h01 << VOUT_OV_FAULT_POS)) | iout_q[IOUT_OC_WARN_POS]
            | |input_q | ven_q[VEN_TSD_POS] | ven_q[VEN_PIN_ONE_POS];
        d.sum_byte = fault_all;
        d.sum_hi = {|vout_q, |iout_q, |input_q, |(ven_q & W1C_VENDOR),
            power_not_good, 3'h0};
        d.rd_valid = rd_en;
        d.rd_unmapped = 1'b0;
        d.rd_data = q.rd_data;
        if (rd_en) begin
            if (cmd_code == OFS_SUMMARY_BYTE || cmd_code == OFS_SUMMARY_WORD) begin
                d.rd_data = q.sum_byte;
            end else if (cmd_code == OFS_VOUT) begin
                d.rd_data = vout_q;
            end else if (cmd_code == OFS_IOUT) begin
                d.rd_data = iout_q;
            end else if (cmd_code == OFS_INPUT) begin
                d.rd_data = input_q;
            end else if (cmd_code == OFS_TEMP) begin
                d.rd_data = temp_q;
            end else if (cmd_code == OFS_CML) begin
                d.rd_data = cml_q;
            end else if (cmd_code == OFS_VENDOR) begin
                d.rd_data = ven_view;
            end else begin
                d.rd_data = 8'h00;
                d.rd_unmapped = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q.mask <= {NUM_STATUS{RST_MASK}};
            q.vin_phase <= VIN_POWERUP;
            q.pin1_fail_cnt <= '0;
            q.pin1_default <= 1'b0;
            q.rd_data <= 8'h00;
            q.rd_valid <= 1'b0;
            q.rd_unmapped <= 1'b0;
            q.alert <= 1'b0;
            q.sum_byte <= RST_SUMMARY_BYTE;
            q.sum_hi <= RST_SUMMARY_HI;
        end else begin
            q <= d;
        end
    end

    assign rd_data = q.rd_data;
    assign rd_valid = q.rd_valid;
    assign rd_unmapped = q.rd_unmapped;
    assign smbalert_oe = q.alert;
    assign address_pin_one_use_default = q.pin1_default;
    assign summary_byte = q.sum_byte;
    assign summary_word_hi = q.sum_hi;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_follower_vout_zero: assert property (@(posedge clk) disable iff (!rst_n)
        loop_follower_indication |=> (vout_q == 8'h00))
        else $error("output flags not held zero in follower mode");

    a_ovf_sets_bit: assert property (@(posedge clk) disable iff (!rst_n)
        (vout_ov_fault && !loop_follower_indication) |=> vout_q[7])
        else $error("overvoltage fault not latched");

    a_zero_write_keeps: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_en && cmd_code == OFS_CML && wr_data == 8'h00 && !clear_faults)
        |=> cml_q == ($past(cml_q) | $past(cml_set)))
        else $error("zero write changed a flag");

    a_one_write_clears: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_en && cmd_code == OFS_IOUT && wr_data[7] && !oc_fault) |=> !iout_q[7])
        else $error("write one did not clear");

    a_powerup_no_alert: assert property (@(posedge clk) disable iff (!rst_n)
        (q.vin_phase == VIN_POWERUP && vout_q == 8'h00 && iout_q == 8'h00
        && temp_q == 8'h00 && cml_q == 8'h00 && (ven_q & W1C_VENDOR) == 8'h00)
        |=> !smbalert_oe)
        else $error("alert during power-up");

    a_lowvin_at_reset: assert property (@(posedge clk) disable iff (!rst_n)
        (q.vin_phase == VIN_POWERUP && !vin_above_on) |=> input_q[3])
        else $error("low input not shown at power-up");

    a_pin1_fourth_fail: assert property (@(posedge clk) disable iff (!rst_n)
        (address_pin_one_attempt && !address_pin_one_ok && q.pin1_fail_cnt == 3'h3)
        |=> (ven_q[4] && address_pin_one_use_default))
        else $error("fourth address failure not flagged");

    a_sync_disable_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_en && cmd_code == OFS_VENDOR && sync_fault_disable) |=> !rd_data[0])
        else $error("sync fault read while disabled");

    a_summary_mirror: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> (summary_byte[5] == $past(vout_q[7])
        && summary_byte[4] == $past(iout_q[7])))
        else $error("summary does not mirror detail bits");

    a_silent_fsm_flags: assert property (@(posedge clk) disable iff (!rst_n)
        (q.mask[5] == 8'h00 && (ven_q & W1C_VENDOR) == 8'h00 && vout_q == 8'h00
        && iout_q == 8'h00 && temp_q == 8'h00 && cml_q == 8'h00
        && q.vin_phase == VIN_RUNNING && input_q == 8'h00) |=> !smbalert_oe)
        else $error("informational flags raised alert");

    c_alert_raised: cover property (@(posedge clk) disable iff (!rst_n)
        !smbalert_oe ##1 smbalert_oe);

    c_vin_running: cover property (@(posedge clk) disable iff (!rst_n)
        q.vin_phase == VIN_POWERUP ##1 q.vin_phase == VIN_RUNNING);

    c_ot_rearm: cover property (@(posedge clk) disable iff (!rst_n)
        temp_q[7] ##1 !temp_q[7] ##[1:20] temp_q[7]);
endmodule
`default_nettype wire

/* pmbus_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Host reading and clearing status
// ----------------------------------------
module pmbus_host_model (
    input wire logic clk,
    output logic rd_en,
    output logic wr_en,
    output logic [7:0] cmd_code,
    output logic [7:0] wr_data,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid
);
    initial begin
        rd_en = 1'b0;
        wr_en = 1'b0;
        cmd_code = 8'h00;
        wr_data = 8'h00;
    end
    task automatic rd(input logic [7:0] c, output logic [7:0] d, output logic ok);
        ok = 1'b0;
        @(negedge clk) rd_en = 1'b1;
        cmd_code = c;
        @(negedge clk) rd_en = 1'b0;
        cmd_code = ~c;
        for (int i = 0; i < 3 && !ok; i++) begin
            ok = rd_valid;
            d = rd_data;
            if (!ok) @(negedge clk);
        end
    endtask
    task automatic wr(input logic [7:0] c, input logic [7:0] v);
        @(negedge clk) wr_en = 1'b1;
        cmd_code = c;
        wr_data = v;
        @(negedge clk) wr_en = 1'b0;
        wr_data = ~v;  // Stale data must not look like a second clear
    endtask
endmodule
`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Status bank bench
// ----------------------------------------
module testbench;
    import pmbus_fault_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, clr = 1'b0, lf = 1'b0, von = 1'b0, voff = 1'b0;
    logic a1 = 1'b0, sync = 1'b0, sdis = 1'b0, cen = 1'b0, rd_en, wr_en, rd_valid, smb, use_def;
    logic [5:0] vev = 6'h00, op = 6'h01;
    logic [8:0] cev = 9'h000;
    logic [7:0] cmd_code, wr_data, rd_data, sbyte;
    logic unm, mwe = 1'b0;
    logic [7:0] mdat = 8'h00, shi;
    logic signed [11:0] temp = 12'sd0, fl = 12'sd100, wl = 12'sd50;
    int miscompares = 0, check_count = 0;
    always #5 clk = ~clk;
    pmbus_host_model host (.clk, .rd_en, .wr_en, .cmd_code, .wr_data, .rd_data, .rd_valid);
    pmbus_fault_status_bank dut (.clk, .rst_n, .rd_en, .wr_en, .cmd_code, .wr_data,
        .clear_faults(clr), .mask_wr_en(mwe), .mask_cmd_code(OFS_VENDOR), .mask_data(mdat),
        .vout_ov_fault(vev[5]), .vout_ov_warn(vev[4]), .vout_uv_warn(vev[3]),
        .vout_uv_fault(vev[2]), .setpoint_range_err(vev[1]), .turn_on_timeout(vev[0]),
        .loop_follower_indication(lf), .oc_fault(cev[6]), .oc_warn(cev[5]),
        .vin_above_on(von), .vin_below_off(voff), .temperature(temp),
        .ot_fault_limit(fl), .ot_warn_limit(wl), .invalid_command(cev[4]),
        .invalid_data(cev[3]), .pec_fail(cev[2]), .memory_fault(cev[1]),
        .other_comm_fault(cev[0]), .bandgap_tsd(cev[7]), .op_state(op),
        .address_pin_one_attempt(a1), .address_pin_one_ok(1'b0),
        .address_pin_zero_detect_fail(cev[8]), .sync_fault_live(sync),
        .sync_fault_disable(sdis), .converter_enabled(cen), .power_not_good(1'b0),
        .rd_data, .rd_valid, .rd_unmapped(unm), .smbalert_oe(smb),
        .address_pin_one_use_default(use_def), .summary_byte(sbyte), .summary_word_hi(shi));
    task automatic complete_run();
        if (miscompares == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rdc(input logic [7:0] c, input logic [7:0] e);
        logic [7:0] d;
        logic ok;
        host.rd(c, d, ok);
        if (ok !== 1'b1) begin
            miscompares++;
            complete_run();
        end else begin
            chk($sformatf("reg %h", c), e, d);
        end
    endtask
    task automatic t_vout();
        for (int k = 0; k < 6; k++) begin
            @(negedge clk) vev = 6'h01 << k;
            @(negedge clk) vev = 6'h00;
            rdc(OFS_VOUT, 8'h04 << k);
            chk("ov_fault_summary", {7'h0, k == 5}, {7'h0, sbyte[5]});
            chk("vout_summary", 8'h80, shi & 8'h80);
            chk("smbalert", 8'h01, {7'h0, smb});
            host.wr(OFS_VOUT, 8'h03);
            rdc(OFS_VOUT, 8'h04 << k);
            host.wr(OFS_VOUT, 8'h04 << k);
            rdc(OFS_VOUT, 8'h00);
            chk("vout_summary", 8'h00, shi & 8'h80);
        end
        lf = 1'b1;
        @(negedge clk) vev = 6'h3f;
        @(negedge clk) vev = 6'h00;
        rdc(OFS_VOUT, 8'h00);
        lf = 1'b0;
    endtask
    task automatic t_vin();
        host.wr(OFS_INPUT, 8'h08);
        rdc(OFS_INPUT, 8'h08);
        chk("smbalert", 8'h00, {7'h0, smb});
        von = 1'b1;
        repeat (2) @(negedge clk);
        rdc(OFS_INPUT, 8'h00);
        von = 1'b0;
        @(negedge clk) voff = 1'b1;
        @(negedge clk) voff = 1'b0;
        rdc(OFS_INPUT, 8'h08);
        chk("smbalert", 8'h01, {7'h0, smb});
        host.wr(OFS_INPUT, 8'h08);
        rdc(OFS_INPUT, 8'h00);
    endtask
    task automatic t_temp();
        temp = wl;
        repeat (3) @(negedge clk);
        rdc(OFS_TEMP, 8'h40);
        temp = wl - 12'sd19;
        host.wr(OFS_TEMP, 8'h40);
        repeat (2) @(negedge clk);
        rdc(OFS_TEMP, 8'h40);
        temp = wl - 12'sd20;
        repeat (2) @(negedge clk);
        host.wr(OFS_TEMP, 8'h40);
        rdc(OFS_TEMP, 8'h00);
        temp = fl;
        repeat (3) @(negedge clk);
        rdc(OFS_TEMP, 8'hc0);
        temp = 12'sd0;
    endtask
    task automatic t_comm();
        @(negedge clk) cev = 9'h1ff;
        @(negedge clk) cev = 9'h000;
        rdc(OFS_IOUT, 8'ha0);
        rdc(OFS_CML, 8'hf2);
        chk("oc_fault_summary", 8'h01, {7'h0, sbyte[4]});
        host.wr(OFS_VENDOR, 8'h08);
        rdc(OFS_VENDOR, 8'h88);
        @(negedge clk) clr = 1'b1;
        @(negedge clk) clr = 1'b0;
        rdc(OFS_CML, 8'h00);
    endtask
    task automatic t_vendor();
        sync = 1'b1;
        repeat (2) @(negedge clk);
        rdc(OFS_VENDOR, 8'h01);
        sdis = 1'b1;
        @(negedge clk);
        rdc(OFS_VENDOR, 8'h00);
        for (int k = 0; k < 4; k++) begin
            @(negedge clk) a1 = 1'b1;
            @(negedge clk) a1 = 1'b0;
            rdc(OFS_VENDOR, k == 3 ? 8'h10 : 8'h00);
        end
        chk("use_default", 8'h01, {7'h0, use_def});
        chk("smbalert", 8'h01, {7'h0, smb});
        @(negedge clk) mwe = 1'b1;
        mdat = 8'h10;
        @(negedge clk) mwe = 1'b0;
        @(negedge clk);
        chk("smbalert_masked", 8'h00, {7'h0, smb});
        @(negedge clk) mwe = 1'b1;
        mdat = 8'h00;
        @(negedge clk) mwe = 1'b0;
        cen = 1'b1;
        repeat (2) @(negedge clk);
        cen = 1'b0;
        rdc(OFS_VENDOR, 8'h10);
        @(negedge clk) clr = 1'b1;
        @(negedge clk) clr = 1'b0;
        @(negedge clk) op = 6'h00;
        @(negedge clk) op = 6'h03;
        @(negedge clk) op = 6'h01;
        rdc(OFS_VENDOR, 8'h60);
        chk("smbalert", 8'h00, {7'h0, smb});
    endtask
    initial begin
        repeat (20) @(negedge clk);
        chk("summary_byte", 8'h41, sbyte);
        rst_n = 1'b1;
        rdc(OFS_VOUT, 8'h00);
        rdc(OFS_INPUT, 8'h08);
        rdc(8'h7f, 8'h00);
        chk("rd_unmapped", 8'h01, {7'h0, unm});
        t_vout();
        t_vin();
        t_temp();
        t_comm();
        t_vendor();
        complete_run();
    end
endmodule
`default_nettype wire
